/* include/idm_mem_if.sv */
/*
  port bundle between the controller and the RAM array.
  assumes both ends run on the same clock; read data come one edge after address.
*/
`timescale 1ns/1ps
`default_nettype none
interface idm_mem_if;
  import idm_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic we;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : idm_mem_if
`default_nettype wire

/* include/idm_pkg.sv */
/*
  constants, command kinds and states shared by the internal data memory block.
  assumes a single system clock domain; the core drives requests on that clock.
*/
// Notes on behaviour
// - 256 bytes of RAM at 0x00 to 0xff
// - lower half reached directly and indirectly
// - upper half reached only through indirect access and the stack
// - direct access above 0x7f goes to special space
// - 0x00..0x1f form four banks of eight registers
// - status word bits 3,4 pick the bank
// - indirect pointer from working reg zero or one
// - 0x20..0x2f also reached as 128 bits
// - bit address equals eight times byte offset plus bit
// - bit versus byte chosen by instruction kind
// - push writes pointer plus one, then increments
// - reset puts stack pointer at 0x07
// - stack may sit anywhere in 256 bytes
// - 32-bit stack record shifts on push or increment
// - stack pointer sits at direct address 0x81
`default_nettype none
package idm_pkg;
  // ****************************************
  // memory map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int RAM_BYTES = 256;
  localparam int REC_BITS = 32;
  localparam logic [7:0] UPPER_FLAG_BIT = 8'h07;
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [3:0] BIT_AREA_HI = 4'h2;
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_BANK_HI = 4;
  localparam int BANK_SHIFT = 3;
  // ****************************************
  // request kinds and controller states
  // ****************************************
  typedef enum logic [2:0] {K_DIRECT, K_INDIRECT, K_BIT, K_PUSH, K_POP} idm_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_PTR, ST_READ, ST_SFR} idm_state_t;
endpackage : idm_pkg
`default_nettype wire

/* logic/idm_data_mem.sv */
/*
  internal data memory: banked working registers, bit area, upper indirect RAM,
  special-space forwarding, stack pointer and stack record.
  assumes the core waits for req_ready_r and samples one-cycle rsp_valid_r pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module idm_data_mem import idm_pkg::*; #(
  parameter int REC_W = REC_BITS
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic clk_en, // freezes all state while low
  input wire logic req_valid, // request present
  input wire idm_kind_t req_kind, // kind of access
  input wire logic req_write, // write when high
  input wire logic [7:0] req_addr, // direct or bit address
  input wire logic req_ptr_sel, // pointer: working_reg_zero or working_reg_one
  input wire logic [7:0] req_wdata, // byte to write or push
  input wire logic req_wbit, // bit value to write
  input wire logic [7:0] program_status_word, // core status word
  input wire logic [7:0] sfr_rdata, // special space read byte
  input wire logic sfr_rbit, // special space read bit
  output logic req_ready_r, // request may be taken
  output logic rsp_valid_r, // answer pulse
  output logic [7:0] rsp_data_r, // byte read
  output logic rsp_bit_r, // bit read
  output logic sfr_req_r, // special space access pulse
  output logic sfr_write_r, // special space write
  output logic sfr_bit_r, // special space bit access
  output logic [7:0] sfr_addr_r, // special space address
  output logic [7:0] sfr_wdata_r, // special space write byte
  output logic sfr_wbit_r, // special space write bit
  output logic [7:0] stack_pointer_r, // stack pointer value
  output logic [REC_W-1:0] stack_record_r // debug stack record
);
  // the shift paths slice [REC_W-2:0], so a one-bit record cannot be served
  if (REC_W < 2) begin : g_bad_rec
    $error("stack record width must be at least two");
  end

  // ****************************************
  // request capture and address decode
  // ****************************************
  idm_mem_if mem_bus ();
  idm_ram u_ram (
    .clk(clk),
    .clk_en(clk_en),
    .bus(mem_bus.mem)
  );

  idm_state_t state_r, state_nxt;
  idm_kind_t kind_r;
  logic write_r;
  logic wbit_r;
  logic [7:0] wdata_r;
  logic [7:0] hold_addr_r;
  logic [2:0] bitpos_r;
  logic take;
  logic [1:0] bank;
  logic [7:0] ptr_addr;
  logic [7:0] bit_byte;
  logic req_upper;
  logic bit_upper;
  logic is_sp;
  logic [7:0] rmw_byte;

  assign take = req_valid && req_ready_r;
  assign bank = {program_status_word[PSW_BANK_HI], program_status_word[PSW_BANK_LO]};
  assign ptr_addr = ({6'h00, bank} << BANK_SHIFT) | {7'h00, req_ptr_sel};
  assign bit_byte = {BIT_AREA_HI, req_addr[6:3]};
  assign req_upper = req_addr[UPPER_FLAG_BIT[2:0]];
  assign bit_upper = req_upper;
  assign is_sp = (req_addr == SP_ADDR);

  always_comb begin
    rmw_byte = mem_bus.rdata;
    rmw_byte[bitpos_r] = wbit_r;
  end

  // ****************************************
  // next state and RAM port
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    mem_bus.addr = hold_addr_r;
    mem_bus.we = 1'b0;
    mem_bus.wdata = wdata_r;
    unique case (state_r)
      ST_IDLE: begin
        if (take) begin
          unique case (req_kind)
            K_DIRECT: begin
              mem_bus.addr = req_addr;
              mem_bus.wdata = req_wdata;
              if (req_upper) begin
                if (!is_sp) begin
                  state_nxt = ST_SFR;
                end
              end else if (req_write) begin
                mem_bus.we = 1'b1;
              end else begin
                state_nxt = ST_READ;
              end
            end
            K_INDIRECT: begin
              mem_bus.addr = ptr_addr;
              state_nxt = ST_PTR;
            end
            K_BIT: begin
              mem_bus.addr = bit_byte;
              state_nxt = bit_upper ? ST_SFR : ST_READ;
            end
            K_PUSH: begin
              mem_bus.addr = 8'(stack_pointer_r + SP_STEP);
              mem_bus.wdata = req_wdata;
              mem_bus.we = 1'b1;
            end
            K_POP: begin
              mem_bus.addr = stack_pointer_r;
              state_nxt = ST_READ;
            end
            default: begin
              state_nxt = ST_IDLE;
            end
          endcase
        end
      end
      ST_PTR: begin
        mem_bus.addr = mem_bus.rdata;
        mem_bus.we = write_r;
        state_nxt = write_r ? ST_IDLE : ST_READ;
      end
      ST_READ: begin
        mem_bus.we = (kind_r == K_BIT) && write_r;
        mem_bus.wdata = rmw_byte;
        state_nxt = ST_IDLE;
      end
      ST_SFR: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      req_ready_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      req_ready_r <= (state_nxt == ST_IDLE);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      kind_r <= K_DIRECT;
      write_r <= 1'b0;
      wbit_r <= 1'b0;
      wdata_r <= 8'h00;
      hold_addr_r <= 8'h00;
      bitpos_r <= 3'h0;
    end else if (clk_en) begin
      if (take) begin
        kind_r <= req_kind;
        write_r <= req_write;
        wbit_r <= req_wbit;
        wdata_r <= req_wdata;
        hold_addr_r <= mem_bus.addr;
        bitpos_r <= req_addr[2:0];
      end else if (state_r == ST_PTR) begin
        hold_addr_r <= mem_bus.rdata;
      end
    end
  end

  // ****************************************
  // stack pointer and record
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_pointer_r <= SP_RESET;
    end else if (clk_en) begin
      if (take && req_kind == K_PUSH) begin
        stack_pointer_r <= 8'(stack_pointer_r + SP_STEP);
      end else if (take && req_kind == K_DIRECT && is_sp && req_write) begin
        stack_pointer_r <= req_wdata;
      end else if (state_r == ST_READ && kind_r == K_POP) begin
        stack_pointer_r <= 8'(stack_pointer_r - SP_STEP);
      end
    end
  end

  // a pop drops the newest record bit so the record tracks stack depth
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_record_r <= '0;
    end else if (clk_en) begin
      if (take && (req_kind == K_PUSH || (req_kind == K_DIRECT && is_sp && req_write
          && req_wdata == 8'(stack_pointer_r + SP_STEP)))) begin
        stack_record_r <= {stack_record_r[REC_W-2:0], 1'b1};
      end else if (state_r == ST_READ && kind_r == K_POP) begin
        stack_record_r <= {1'b0, stack_record_r[REC_W-1:1]};
      end
    end
  end

  // ****************************************
  // special space forwarding
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_req_r <= 1'b0;
      sfr_write_r <= 1'b0;
      sfr_bit_r <= 1'b0;
      sfr_addr_r <= 8'h00;
      sfr_wdata_r <= 8'h00;
      sfr_wbit_r <= 1'b0;
    end else if (clk_en) begin
      sfr_req_r <= take && state_nxt == ST_SFR;
      if (take && state_nxt == ST_SFR) begin
        sfr_write_r <= req_write;
        sfr_bit_r <= (req_kind == K_BIT);
        sfr_addr_r <= req_addr;
        sfr_wdata_r <= req_wdata;
        sfr_wbit_r <= req_wbit;
      end
    end
  end

  // ****************************************
  // answers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_bit_r <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (take && state_nxt == ST_IDLE) begin
            rsp_valid_r <= 1'b1;
            if (req_kind == K_DIRECT && is_sp) begin
              rsp_data_r <= stack_pointer_r;
            end
          end
        end
        ST_PTR: begin
          rsp_valid_r <= write_r;
        end
        ST_READ: begin
          rsp_valid_r <= 1'b1;
          rsp_data_r <= mem_bus.rdata;
          rsp_bit_r <= mem_bus.rdata[bitpos_r];
        end
        ST_SFR: begin
          rsp_valid_r <= 1'b1;
          rsp_data_r <= sfr_rdata;
          rsp_bit_r <= sfr_rbit;
        end
      endcase
    end
  end
endmodule : idm_data_mem
`default_nettype wire

/* logic/idm_ram.sv */
/*
  single-port byte array with registered read data.
  assumes the controller holds address and write strobe for one enabled edge.
*/
`timescale 1ns/1ps
`default_nettype none
module idm_ram import idm_pkg::*; #(
  parameter int DEPTH = RAM_BYTES
) (
  input wire logic clk, // system clock
  input wire logic clk_en, // freezes the array while low
  idm_mem_if.mem bus // controller side
);
  if (DEPTH != (1 << ADDR_W)) begin : g_bad_depth
    $error("idm_ram depth must match the address width");
  end

  logic [DATA_W-1:0] cells [DEPTH];

  // no reset on the array: contents are undefined at power-up, as in any RAM
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (bus.we) begin
        cells[bus.addr] <= bus.wdata;
      end
      bus.rdata <= cells[bus.addr];
    end
  end
endmodule : idm_ram
`default_nettype wire

/* tb/idm_data_mem_assertions.sv */
/*
  timing checks on the data memory ports.
  assumes one clock and the core request handshake.
*/
`timescale 1ns/1ps
`default_nettype none
module idm_data_mem_assertions import idm_pkg::*; #(
  parameter int REC_W = REC_BITS
) (
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic clk_en, // enable
  input wire logic req_valid, // request
  input wire idm_kind_t req_kind, // kind
  input wire logic req_write, // write
  input wire logic [7:0] req_addr, // address
  input wire logic [7:0] req_wdata, // data
  input wire logic req_ready_r, // ready
  input wire logic rsp_valid_r, // answer
  input wire logic sfr_req_r, // forward
  input wire logic sfr_bit_r, // bit forward
  input wire logic [7:0] sfr_addr_r, // forward address
  input wire logic [7:0] stack_pointer_r, // pointer
  input wire logic [REC_W-1:0] stack_record_r // record
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic take;
  logic [REC_W-1:0] rec_shl;
  assign take = clk_en && req_valid && req_ready_r;
  assign rec_shl = {stack_record_r[REC_W-2:0], 1'b1};
  property p_push_sp;
    take && req_kind == K_PUSH |=> stack_pointer_r == $past(stack_pointer_r) + SP_STEP;
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push missed pointer step");
  property p_push_rec;
    take && req_kind == K_PUSH |=> stack_record_r == $past(rec_shl);
  endproperty
  a_push_rec: assert property (p_push_rec) else $error("record not shifted");
  property p_pop_sp;
    take && req_kind == K_POP |-> ##2 rsp_valid_r && stack_pointer_r == $past(stack_pointer_r, 2) - SP_STEP;
  endproperty
  a_pop_sp: assert property (p_pop_sp) else $error("pop missed pointer step");
  property p_sfr_fwd;
    take && req_kind == K_DIRECT && req_addr[7] && req_addr != SP_ADDR |=> sfr_req_r && !sfr_bit_r
      && sfr_addr_r == $past(req_addr);
  endproperty
  a_sfr_fwd: assert property (p_sfr_fwd) else $error("high direct not forwarded");
  property p_ind_stay;
    take && req_kind == K_INDIRECT |=> !sfr_req_r [*3];
  endproperty
  a_ind_stay: assert property (p_ind_stay) else $error("indirect left the ram");
  property p_ind_rd;
    take && req_kind == K_INDIRECT && !req_write |=> !rsp_valid_r ##1 !rsp_valid_r ##1 rsp_valid_r;
  endproperty
  a_ind_rd: assert property (p_ind_rd) else $error("indirect read timing");
  property p_bit_lo;
    take && req_kind == K_BIT && !req_addr[7] |=> !sfr_req_r ##1 rsp_valid_r;
  endproperty
  a_bit_lo: assert property (p_bit_lo) else $error("low bit access misrouted");
  property p_bit_hi;
    take && req_kind == K_BIT && req_addr[7] |=> sfr_req_r && sfr_bit_r;
  endproperty
  a_bit_hi: assert property (p_bit_hi) else $error("high bit not forwarded as bit");
  property p_sp_load;
    take && req_kind == K_DIRECT && req_write && req_addr == SP_ADDR |=> stack_pointer_r == $past(req_wdata);
  endproperty
  a_sp_load: assert property (p_sp_load) else $error("pointer write lost");
  property p_rst;
    $fell(sys_rst) |-> stack_pointer_r == SP_RESET && stack_record_r == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("pointer reset value wrong");
  c_push: cover property (take && req_kind == K_PUSH);
  c_pop: cover property (take && req_kind == K_POP);
  c_fwd: cover property (sfr_req_r);
endmodule : idm_data_mem_assertions
bind idm_data_mem idm_data_mem_assertions #(.REC_W(REC_W)) i_idm_data_mem_assertions (.clk, .sys_rst, .clk_en,
  .req_valid, .req_kind, .req_write, .req_addr, .req_wdata, .req_ready_r, .rsp_valid_r, .sfr_req_r, .sfr_bit_r,
  .sfr_addr_r, .stack_pointer_r, .stack_record_r);
`default_nettype wire

/* tb/idm_sfr_model.sv */
/*
  special-space responder standing in for the registers beyond 0x7f.
  assumes answers matter only while sfr_req_r is high.
*/
`timescale 1ns/1ps
`default_nettype none
module idm_sfr_model (
  input wire logic clk, // system clock
  input wire logic sfr_req_r, // access pulse
  input wire logic [7:0] sfr_addr_r, // access address
  output logic [7:0] sfr_rdata, // answer byte
  output logic sfr_rbit // answer bit
);
  // ****************
  // answer
  // ****************
  logic [7:0] churn_r = 8'h00;
  // outside a request the lines carry junk that moves every cycle
  always_ff @(posedge clk) churn_r <= churn_r + 8'h35;
  assign sfr_rdata = sfr_req_r ? ~sfr_addr_r : churn_r;
  assign sfr_rbit = sfr_req_r ? sfr_addr_r[0] : churn_r[0];
endmodule : idm_sfr_model
`default_nettype wire

/* tb/test_internal_data_memory_stack.sv */
/*
  self-checking bench for the internal data memory.
  assumes the special-space responder model sits on the forward port.
*/
`timescale 1ns/1ps
`default_nettype none
module test_internal_data_memory_stack;
  import idm_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_ptr_sel = 1'b0, req_wbit = 1'b0;
  logic clk_en = 1'b1;
  idm_kind_t req_kind = K_DIRECT;
  logic [7:0] req_addr = 8'h00, req_wdata = 8'h00, program_status_word = 8'h00, rdat;
  logic [7:0] sfr_rdata, rsp_data_r, sfr_addr_r, sfr_wdata_r, stack_pointer_r;
  logic sfr_rbit, rbit, req_ready_r, rsp_valid_r, rsp_bit_r, sfr_req_r, sfr_write_r, sfr_bit_r, sfr_wbit_r;
  logic [31:0] stack_record_r;
  int err_total = 0, checked = 0;
  idm_data_mem i_idm_data_mem (.clk, .sys_rst, .clk_en, .req_valid, .req_kind, .req_write, .req_addr,
    .req_ptr_sel, .req_wdata, .req_wbit, .program_status_word, .sfr_rdata, .sfr_rbit, .req_ready_r, .rsp_valid_r,
    .rsp_data_r, .rsp_bit_r, .sfr_req_r, .sfr_write_r, .sfr_bit_r, .sfr_addr_r, .sfr_wdata_r, .sfr_wbit_r,
    .stack_pointer_r, .stack_record_r);
  idm_sfr_model i_idm_sfr_model (.clk, .sfr_req_r, .sfr_addr_r, .sfr_rdata, .sfr_rbit);
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ****************
  // one core access
  // ****************
  task automatic acc(input idm_kind_t k, input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic b = 1'b0);
    int n;
    while (!req_ready_r) @(negedge clk);
    req_kind = k;
    req_write = w;
    req_addr = a;
    req_ptr_sel = a[0];
    req_wdata = d;
    req_wbit = b;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; n < 8 && !rsp_valid_r; n++) @(negedge clk);
    chk(rsp_valid_r, 1'b1);
    rdat = rsp_data_r;
    rbit = rsp_bit_r;
    // a spare cycle keeps the next raise of valid off this edge
    @(negedge clk);
  endtask : acc
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  initial begin
    #20000;
    err_total++;
    close_out;
  end
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    chk(stack_pointer_r, SP_RESET);
    chk(stack_record_r, 32'h0);
    @(negedge clk);
    acc(K_DIRECT, 1'b1, 8'h7f, 8'h5a);
    acc(K_DIRECT, 1'b0, 8'h7f, 8'h00);
    chk(rdat, 8'h5a);
    acc(K_DIRECT, 1'b1, 8'h10, 8'h90);
    program_status_word = 8'h10;
    acc(K_INDIRECT, 1'b1, 8'h00, 8'ha5);
    acc(K_DIRECT, 1'b0, 8'h90, 8'h00);
    chk(rdat, 8'h6f);
    acc(K_DIRECT, 1'b1, 8'h90, 8'h3e);
    chk({sfr_write_r, sfr_addr_r, sfr_wdata_r}, {1'b1, 8'h90, 8'h3e});
    acc(K_INDIRECT, 1'b0, 8'h00, 8'h00);
    chk(rdat, 8'ha5);
    $display("test map done");
    for (int b = 0; b < 4; b++) begin
      program_status_word = 8'(b << PSW_BANK_LO);
      acc(K_DIRECT, 1'b1, 8'(8 * b + 1), 8'(8'hc0 + b));
      acc(K_INDIRECT, 1'b1, 8'h01, 8'(b));
    end
    for (int b = 0; b < 4; b++) begin
      program_status_word = 8'(b << PSW_BANK_LO);
      acc(K_INDIRECT, 1'b0, 8'h01, 8'h00);
      chk(rdat, 8'(b));
    end
    $display("test banks done");
    acc(K_DIRECT, 1'b1, 8'h20, 8'h80);
    acc(K_DIRECT, 1'b1, 8'h22, 8'h00);
    acc(K_BIT, 1'b1, 8'h13, 8'h00, 1'b1);
    acc(K_DIRECT, 1'b0, 8'h22, 8'h00);
    chk(rdat, 8'h08);
    acc(K_BIT, 1'b0, 8'h07, 8'h00);
    chk(rbit, 1'b1);
    acc(K_BIT, 1'b0, 8'h85, 8'h00);
    chk(rbit, 1'b1);
    acc(K_BIT, 1'b1, 8'h8a, 8'h00, 1'b1);
    chk({sfr_bit_r, sfr_wbit_r, sfr_addr_r}, {1'b1, 1'b1, 8'h8a});
    $display("test bits done");
    acc(K_PUSH, 1'b0, 8'h00, 8'h3c);
    chk(stack_pointer_r, 8'h08);
    chk(stack_record_r, 32'h1);
    acc(K_DIRECT, 1'b0, 8'h08, 8'h00);
    chk(rdat, 8'h3c);
    acc(K_POP, 1'b0, 8'h00, 8'h00);
    chk(rdat, 8'h3c);
    chk(stack_pointer_r, SP_RESET);
    chk(stack_record_r, 32'h0);
    acc(K_DIRECT, 1'b1, SP_ADDR, 8'hfe);
    acc(K_DIRECT, 1'b0, SP_ADDR, 8'h00);
    chk(rdat, 8'hfe);
    acc(K_PUSH, 1'b0, 8'h00, 8'h77);
    program_status_word = 8'h00;
    acc(K_DIRECT, 1'b1, 8'h00, 8'hff);
    acc(K_INDIRECT, 1'b0, 8'h00, 8'h00);
    chk(rdat, 8'h77);
    acc(K_DIRECT, 1'b1, SP_ADDR, 8'h00);
    chk(stack_record_r, 32'h3);
    $display("test stack done");
    // a request offered while the enable is low must leave no trace
    clk_en = 1'b0;
    req_kind = K_PUSH;
    req_wdata = 8'h11;
    req_valid = 1'b1;
    repeat (3) @(negedge clk);
    chk(rsp_valid_r, 1'b0);
    chk(stack_pointer_r, 8'h00);
    req_valid = 1'b0;
    clk_en = 1'b1;
    @(negedge clk);
    chk(rsp_valid_r, 1'b0);
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    chk(stack_pointer_r, SP_RESET);
    chk(stack_record_r, 32'h0);
    acc(K_DIRECT, 1'b0, SP_ADDR, 8'h00);
    chk(rdat, SP_RESET);
    $display("test freeze and reset done");
    close_out;
  end
endmodule : test_internal_data_memory_stack
`default_nettype wire
